// ===== verilog/cwc_pkg.sv
// Constants shared by the waveform control block: offsets, fields, codes.
// Assumes a 32-bit APB with byte addresses and one word per register.
package cwc_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_MAIN = 8'h00;
  localparam logic [7:0] OFS_POL  = 8'h04;
  localparam logic [7:0] OFS_RISE = 8'h08;
  localparam logic [7:0] OFS_FALL = 8'h0c;
  localparam logic [7:0] OFS_SD   = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_EN     = 7;
  localparam int BIT_LOAD   = 6;
  localparam int BIT_IN     = 5;
  localparam int BIT_SD     = 7;
  localparam int BIT_REN    = 6;
  localparam int LSB_LVL_BD = 4;
  localparam int LSB_LVL_AC = 2;

  // ****************************************
  // Operating modes and override codes
  // ****************************************
  localparam logic [2:0] MODE_STEER_ASYNC = 3'h0;
  localparam logic [2:0] MODE_STEER_SYNC  = 3'h1;
  localparam logic [2:0] MODE_FULL_FWD    = 3'h2;
  localparam logic [2:0] MODE_FULL_REV    = 3'h3;
  localparam logic [2:0] MODE_HALF        = 3'h4;
  localparam logic [2:0] MODE_PUSH_PULL   = 3'h5;
  localparam logic [1:0] LVL_HIGH         = 2'h3;
  localparam logic [1:0] LVL_LOW          = 2'h2;
  localparam logic [1:0] LVL_FLOAT        = 2'h1;
  localparam logic [1:0] LVL_INACTIVE     = 2'h0;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [2:0] RST_MODE  = 3'h0;
  localparam logic [3:0] RST_POL   = 4'h0;
  localparam logic [5:0] RST_DELAY = 6'h00;
  localparam logic [1:0] RST_LVL   = 2'h1;

endpackage

// ===== verilog/cwc_sync.sv
// Three-stage synchroniser with agreement filter for one pin level.
// Assumes the pin is asynchronous to pclk; output changes once stages agree.
`timescale 1ns/100ps
module cwc_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin level and filtered copy
  input  wire logic async_in,
  output logic      level_out
);

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
  } cwc_sync_state_t;

  cwc_sync_state_t st;
  cwc_sync_state_t next_st;

  // ****************************************
  // Stages
  // ****************************************
  // First stage feeds only the second, to keep metastability contained
  always_comb begin
    next_st     = st;
    next_st.ff1 = async_in;
    next_st.ff2 = st.ff1;
    next_st.ff3 = st.ff2;
    if (st.ff2 == st.ff3) begin
      next_st.level = st.ff3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.level;

endmodule

// ===== verilog/cwc_top.sv
// Complementary waveform control: APB registers, dead-band, shutdown.
// Assumes one selected input waveform and one combined shutdown request.
//
// Notes on behaviour
// - Enable bit turns generator on, resets off
// - Load bit copies buffers on edge, self-clears
// - Mode field selects steering, bridge, push-pull
// - Per-output polarity bits invert each output
// - Rising dead-band delays output on rising edge
// - Falling dead-band delays output on falling edge
// - Shutdown status set by hardware or software
// - Auto-restart leaves shutdown without software
// - B/D override drives high, low or float
// - A/C override drives high, low or float
// - Code 00 gives inactive level after dead-band
// - Shutdown bit writable while module disabled
// - Overrides hold until next input rising edge
// - Auto-restart clears status once request drops
// - Software clear ignored while request active
// - Polarity never alters fixed override levels
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module cwc_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Input waveform and shutdown request pins
  input  wire logic        wave_in,
  input  wire logic        shutdown_req,
  // Power stage outputs
  output logic             output_a,
  output logic             output_b,
  output logic             output_c,
  output logic             output_d,
  output logic             output_a_oe,
  output logic             output_b_oe,
  output logic             output_c_oe,
  output logic             output_d_oe
);

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        en;
    logic        buffer_load;
    logic [2:0]  mode;
    logic [3:0]  pol;
    logic [5:0]  rise_buf;
    logic [5:0]  fall_buf;
    logic [5:0]  rise_act;
    logic [5:0]  fall_act;
    logic        sd_flag;
    logic        ren;
    logic [1:0]  lvl_bd;
    logic [1:0]  lvl_ac;
    logic        data_q;
    logic        hs;
    logic        ls;
    logic        pp;
    logic [5:0]  rcnt;
    logic [5:0]  fcnt;
    logic [5:0]  sd_dly;
    logic        sd_hold;
    logic [3:0]  out;
    logic [3:0]  oe;
  } cwc_state_t;

  cwc_state_t  st;
  cwc_state_t  next_st;
  logic        wave_lvl;
  logic        sd_lvl;
  logic        evt_rise;
  logic        evt_fall;
  logic        setup;
  logic        wr;
  logic        hit;
  logic [31:0] rd_val;
  logic        wr_main;
  logic        wr_pol;
  logic        wr_rise;
  logic        wr_fall;
  logic        wr_sd;
  logic        load_evt;
  logic        sd_clear;
  logic [3:0]  wave;
  logic [3:0]  gen_out;
  logic [3:0]  gen_oe;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  cwc_sync u_sync_wave (
    .pclk      (pclk),
    .presetn   (presetn),
    .async_in  (wave_in),
    .level_out (wave_lvl)
  );

  cwc_sync u_sync_sd (
    .pclk      (pclk),
    .presetn   (presetn),
    .async_in  (shutdown_req),
    .level_out (sd_lvl)
  );

  assign evt_rise = wave_lvl & ~st.data_q;
  assign evt_fall = ~wave_lvl & st.data_q;

  // ****************************************
  // APB decode
  // ****************************************
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & st.pready & pwrite;
  assign hit     = (paddr == cwc_pkg::OFS_MAIN) | (paddr == cwc_pkg::OFS_POL) |
                   (paddr == cwc_pkg::OFS_RISE) | (paddr == cwc_pkg::OFS_FALL) |
                   (paddr == cwc_pkg::OFS_SD);
  assign wr_main = wr & (paddr == cwc_pkg::OFS_MAIN);
  assign wr_pol  = wr & (paddr == cwc_pkg::OFS_POL);
  assign wr_rise = wr & (paddr == cwc_pkg::OFS_RISE);
  assign wr_fall = wr & (paddr == cwc_pkg::OFS_FALL);
  assign wr_sd   = wr & (paddr == cwc_pkg::OFS_SD);

  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      cwc_pkg::OFS_MAIN: rd_val = {24'h00_0000, st.en, st.buffer_load, 3'h0, st.mode};
      cwc_pkg::OFS_POL:  rd_val = {24'h00_0000, 2'h0, st.data_q, 1'h0, st.pol};
      cwc_pkg::OFS_RISE: rd_val = {24'h00_0000, 2'h0, st.rise_buf};
      cwc_pkg::OFS_FALL: rd_val = {24'h00_0000, 2'h0, st.fall_buf};
      cwc_pkg::OFS_SD:   rd_val = {24'h00_0000, st.sd_flag, st.ren, st.lvl_bd, st.lvl_ac, 2'h0};
      default:           rd_val = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Waveform per mode
  // ****************************************
  // Mode steering
  always_comb begin
    case (st.mode)
      cwc_pkg::MODE_STEER_ASYNC: wave = {4{st.data_q}};
      cwc_pkg::MODE_STEER_SYNC:  wave = {4{st.data_q}};
      cwc_pkg::MODE_FULL_FWD:    wave = {st.hs, 1'b0, 1'b0, 1'b1};
      cwc_pkg::MODE_FULL_REV:    wave = {1'b0, 1'b1, st.hs, 1'b0};
      cwc_pkg::MODE_HALF:        wave = {st.ls, st.hs, st.ls, st.hs};
      cwc_pkg::MODE_PUSH_PULL:   wave = {2{st.hs & st.pp, st.hs & ~st.pp}};
      default:                   wave = 4'h0;
    endcase
  end

  // ****************************************
  // Output stage per pin
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      logic [1:0] code;
      logic       norm;
      assign code = (gi % 2 == 0) ? st.lvl_ac : st.lvl_bd;
      assign norm = wave[gi] ^ st.pol[gi];
      assign gen_out[gi] = !st.sd_hold ? (st.en & norm) :
                           (code == cwc_pkg::LVL_HIGH)  ? 1'b1 :
                           (code == cwc_pkg::LVL_LOW)   ? 1'b0 :
                           (code == cwc_pkg::LVL_FLOAT) ? 1'b0 :
                           (st.sd_dly == 6'h00)         ? st.pol[gi] : (st.en & norm);
      assign gen_oe[gi]  = !st.sd_hold ? st.en : (code != cwc_pkg::LVL_FLOAT);
    end
  endgenerate

  assign load_evt = st.en & st.buffer_load & (evt_rise | evt_fall);
  assign sd_clear = ~sd_lvl & ((wr_sd & ~pwdata[cwc_pkg::BIT_SD]) | st.ren);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st         = st;
    next_st.pready  = setup;
    next_st.pslverr = setup & ~hit;
    if (setup && !pwrite) begin
      next_st.prdata = rd_val;
    end
    if (wr_main) begin
      next_st.en   = pwdata[cwc_pkg::BIT_EN];
      next_st.mode = pwdata[2:0];
    end
    next_st.buffer_load = (wr_main & pwdata[cwc_pkg::BIT_LOAD] & st.en) |
                          (st.buffer_load & ~load_evt);
    if (wr_pol) begin
      next_st.pol = pwdata[3:0];
    end
    if (wr_rise) begin
      next_st.rise_buf = pwdata[5:0];
    end
    if (wr_fall) begin
      next_st.fall_buf = pwdata[5:0];
    end
    // Disabled module tracks the buffers directly
    if (!st.en || load_evt) begin
      next_st.rise_act = st.rise_buf;
      next_st.fall_act = st.fall_buf;
    end
    if (wr_sd) begin
      next_st.ren    = pwdata[cwc_pkg::BIT_REN];
      next_st.lvl_bd = pwdata[cwc_pkg::LSB_LVL_BD +: 2];
      next_st.lvl_ac = pwdata[cwc_pkg::LSB_LVL_AC +: 2];
    end
    next_st.sd_flag = sd_lvl | (wr_sd & pwdata[cwc_pkg::BIT_SD]) |
                      (st.sd_flag & ~sd_clear);
    next_st.sd_hold = next_st.sd_flag | (st.sd_hold & ~evt_rise);
    if (!st.sd_hold) begin
      next_st.sd_dly = st.fall_act;
    end else if (st.sd_dly != 6'h00) begin
      next_st.sd_dly = st.sd_dly - 6'h01;
    end
    next_st.data_q = wave_lvl;
    if (evt_rise) begin
      next_st.pp = ~st.pp;
    end
    if (!st.en || evt_fall) begin
      next_st.hs   = 1'b0;
      next_st.rcnt = 6'h00;
    end else if (evt_rise) begin
      next_st.hs   = (st.rise_act == 6'h00);
      next_st.rcnt = st.rise_act;
    end else if (st.rcnt != 6'h00) begin
      next_st.rcnt = st.rcnt - 6'h01;
      next_st.hs   = (st.rcnt == 6'h01);
    end
    if (!st.en || evt_rise) begin
      next_st.ls   = 1'b0;
      next_st.fcnt = 6'h00;
    end else if (evt_fall) begin
      next_st.ls   = (st.fall_act == 6'h00);
      next_st.fcnt = st.fall_act;
    end else if (st.fcnt != 6'h00) begin
      next_st.fcnt = st.fcnt - 6'h01;
      next_st.ls   = (st.fcnt == 6'h01);
    end
    next_st.out = gen_out;
    next_st.oe  = gen_oe;
  end

  // ****************************************
  // State register
  // ****************************************
  // Dead-band values get a known reset; only one reset exists here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.mode     <= cwc_pkg::RST_MODE;
      st.pol      <= cwc_pkg::RST_POL;
      st.rise_buf <= cwc_pkg::RST_DELAY;
      st.fall_buf <= cwc_pkg::RST_DELAY;
      st.rise_act <= cwc_pkg::RST_DELAY;
      st.fall_act <= cwc_pkg::RST_DELAY;
      st.lvl_bd   <= cwc_pkg::RST_LVL;
      st.lvl_ac   <= cwc_pkg::RST_LVL;
    end else begin
      st <= next_st;
    end
  end

  assign prdata      = st.prdata;
  assign pready      = st.pready;
  assign pslverr     = st.pslverr;
  assign output_a    = st.out[0];
  assign output_b    = st.out[1];
  assign output_c    = st.out[2];
  assign output_d    = st.out[3];
  assign output_a_oe = st.oe[0];
  assign output_b_oe = st.oe[1];
  assign output_c_oe = st.oe[2];
  assign output_d_oe = st.oe[3];

  // ****************************************
  // Assertions
  // ****************************************
  a_disabled_float: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!st.en && !st.sd_hold) |=> (st.oe == 4'h0) && (st.out == 4'h0))
    else $error("disabled module drives pins");

  a_load_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    (load_evt && !wr_main) |=> !st.buffer_load && (st.rise_act == $past(st.rise_buf)))
    else $error("buffer load did not complete");

  a_reserved_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.en && !st.sd_hold && st.mode[2:1] == 2'h3) |=> (st.out == $past(st.pol)))
    else $error("reserved mode not inactive");

  a_half_polarity: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.en && !st.sd_hold && st.mode == cwc_pkg::MODE_HALF)
      |=> (st.out[1:0] == $past({st.ls, st.hs} ^ st.pol[1:0])))
    else $error("polarity not applied");

  a_rise_delay: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.en && evt_rise && st.rise_act == 6'h03) ##1 (st.en && wave_lvl)[*3] |=> st.hs)
    else $error("rising dead-band wrong");

  a_fall_delay: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.en && evt_fall && st.fall_act != 6'h00) |=> !st.ls && (st.fcnt == $past(st.fall_act)))
    else $error("falling dead-band too short");

  a_hw_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    sd_lvl |=> st.sd_flag && st.sd_hold)
    else $error("shutdown not entered");

  a_manual_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.sd_flag && !st.ren && !wr_sd) |=> st.sd_flag)
    else $error("shutdown cleared without software");

  a_bd_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.sd_hold && st.lvl_bd == cwc_pkg::LVL_HIGH) |=> output_b && output_d && output_b_oe)
    else $error("B/D override not high");

  a_ac_float: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.sd_hold && st.lvl_ac == cwc_pkg::LVL_FLOAT) |=> !output_a_oe && !output_c_oe)
    else $error("A/C override not floating");

  a_inactive_lvl: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.sd_hold && st.sd_dly == 6'h00 && st.lvl_ac == cwc_pkg::LVL_INACTIVE)
      |=> (output_a == $past(st.pol[0])) && output_a_oe)
    else $error("inactive override level wrong");

  a_hold_to_rise: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.sd_hold && !evt_rise) |=> st.sd_hold)
    else $error("override released before rising edge");

  a_auto_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.sd_flag && st.ren && !sd_lvl && !wr_sd) |=> !st.sd_flag)
    else $error("auto-restart did not clear");

  a_clear_blocked: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sd_lvl && st.sd_flag) |=> st.sd_flag)
    else $error("shutdown cleared while request active");

endmodule

// ===== verification/cwc_stage.sv
// Power stage model: the four switch drivers behind the output pins.
// Assumes each pin has a weak pull-down, so a released pin reads low.
`timescale 1ns/100ps
module cwc_stage (
  // Pins from the block, order d c b a
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  // Levels seen by the switches
  output logic      [3:0] pin_lvl
);
  // ****************************************
  // Pin resolution
  // ****************************************
  // Pull-down wins only when the block lets go
  assign pin_lvl = pin_out & pin_oe;
endmodule

// ===== verification/complementary_waveform_control_test.sv
// Testbench for the waveform control block: APB tasks and scenario list.
// Assumes zero or more wait states on APB and a 4-cycle input synchroniser.
`timescale 1ns/100ps
module complementary_waveform_control_test;
  // ****************************************
  // Signals
  // ****************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        wave_in, shutdown_req, rd_e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0]  o, oe, pins;
  int          n_fail, total_checks, m, w;

  always #4 pclk = ~pclk;

  cwc_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wave_in(wave_in),
    .shutdown_req(shutdown_req), .output_a(o[0]), .output_b(o[1]),
    .output_c(o[2]), .output_d(o[3]), .output_a_oe(oe[0]), .output_b_oe(oe[1]),
    .output_c_oe(oe[2]), .output_d_oe(oe[3]));

  cwc_stage stage_u (.pin_out(o), .pin_oe(oe), .pin_lvl(pins));

  // ****************************************
  // Tasks
  // ****************************************
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task fail(input string s);
    n_fail++;
    $display("[FAIL] %0t %s", $time, s);
  endtask

  // Held until pready is seen high at a rising edge
  task xfer(input logic [7:0] a, input logic wr_n, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr_n;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      fail("no ready");
      report_and_stop;
    end
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task chk_reg(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) fail($sformatf("register %h expected %h", g, e));
  endtask

  task chk_pins(input logic [3:0] g, input logic [3:0] e);
    total_checks++;
    if (g !== e) fail($sformatf("pins %b expected %b", g, e));
  endtask

  task chk_cnt(input int g, input int e);
    total_checks++;
    if (g != e) fail($sformatf("delay %0d expected %0d", g, e));
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h000000, d});
  endtask

  // Unmapped places answer with an error and zero
  task rd(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 32'h00000000);
    chk_reg(rd_v, {24'h000000, e});
    chk_reg({31'h00000000, rd_e}, {31'h00000000, a > cwc_pkg::OFS_SD});
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task drv(input logic wv, input logic sd);
    @(posedge pclk);
    wave_in <= wv;
    shutdown_req <= sd;
  endtask

  // Cycles from the input edge until pin idx goes high
  task measure(input logic v, input int idx, input int e);
    int k;
    drv(v, shutdown_req);
    for (k = 1; k < 100; k++) begin
      @(posedge pclk);
      #1;
      if (pins[idx] === 1'b1) break;
    end
    chk_cnt(k, e);
  endtask

  function automatic logic [3:0] exp_pins(input logic [2:0] md, input logic wv);
    case (md)
      3'h0, 3'h1: return {4{wv}};
      3'h2:       return {wv, 2'b00, 1'b1};
      3'h3:       return {2'b01, wv, 1'b0};
      3'h4:       return {~wv, wv, ~wv, wv};
      default:    return 4'h0;
    endcase
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {pclk, psel, penable, pwrite, wave_in, shutdown_req, presetn} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    n_fail = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(cwc_pkg::OFS_MAIN, 8'h00);
    rd(cwc_pkg::OFS_POL, 8'h00);
    rd(cwc_pkg::OFS_RISE, 8'h00);
    rd(cwc_pkg::OFS_FALL, 8'h00);
    rd(cwc_pkg::OFS_SD, 8'h14);
    rd(8'h14, 8'h00);
    wr(cwc_pkg::OFS_POL, 8'hff);
    rd(cwc_pkg::OFS_POL, 8'h0f);
    wr(cwc_pkg::OFS_RISE, 8'hff);
    rd(cwc_pkg::OFS_RISE, 8'h3f);
    wr(cwc_pkg::OFS_FALL, 8'h2a);
    rd(cwc_pkg::OFS_FALL, 8'h2a);
    wr(cwc_pkg::OFS_POL, 8'h00);
    wr(cwc_pkg::OFS_RISE, 8'h00);
    wr(cwc_pkg::OFS_FALL, 8'h00);
    drv(1'b1, 1'b0);
    cyc(8);
    rd(cwc_pkg::OFS_POL, 8'h20);
    // Every mode code, both input levels
    for (m = 0; m < 8; m++) begin
      wr(cwc_pkg::OFS_MAIN, {5'h10, m[2:0]});
      rd(cwc_pkg::OFS_MAIN, {5'h10, m[2:0]});
      for (w = 0; w < 2; w++) begin
        drv(w[0], 1'b0);
        cyc(12);
        if (m == 5)
          chk_pins(pins, w[0] ? {2{pins[1], ~pins[1]}} : 4'h0);
        else
          chk_pins(pins, exp_pins(m[2:0], w[0]));
      end
    end
    wr(cwc_pkg::OFS_MAIN, 8'h84);
    wr(cwc_pkg::OFS_POL, 8'h05);
    cyc(12);
    chk_pins(pins, exp_pins(3'h4, 1'b1) ^ 4'h5);
    wr(cwc_pkg::OFS_POL, 8'h00);
    // Dead-band counts; active copies follow buffers while disabled or on a load edge
    wr(cwc_pkg::OFS_MAIN, 8'h04);
    wr(cwc_pkg::OFS_RISE, 8'h0a);
    wr(cwc_pkg::OFS_FALL, 8'h14);
    wr(cwc_pkg::OFS_MAIN, 8'h84);
    drv(1'b0, 1'b0);
    cyc(40);
    measure(1'b1, 0, 16);
    measure(1'b0, 1, 26);
    wr(cwc_pkg::OFS_RISE, 8'h03);
    measure(1'b1, 0, 16);
    wr(cwc_pkg::OFS_MAIN, 8'hc4);
    rd(cwc_pkg::OFS_MAIN, 8'hc4);
    measure(1'b0, 1, 26);
    rd(cwc_pkg::OFS_MAIN, 8'h84);
    measure(1'b1, 0, 9);
    // Shutdown with fixed levels under inverted polarity
    wr(cwc_pkg::OFS_POL, 8'h0f);
    wr(cwc_pkg::OFS_SD, 8'h2c);
    cyc(40);
    drv(1'b1, 1'b1);
    cyc(8);
    chk_pins(pins, 4'h5);
    rd(cwc_pkg::OFS_SD, 8'hac);
    wr(cwc_pkg::OFS_SD, 8'h2c);
    rd(cwc_pkg::OFS_SD, 8'hac);
    drv(1'b1, 1'b0);
    cyc(8);
    rd(cwc_pkg::OFS_SD, 8'hac);
    wr(cwc_pkg::OFS_SD, 8'h2c);
    rd(cwc_pkg::OFS_SD, 8'h2c);
    cyc(4);
    chk_pins(pins, 4'h5);
    drv(1'b0, 1'b0);
    cyc(30);
    drv(1'b1, 1'b0);
    cyc(30);
    chk_pins(pins, 4'ha);
    // Auto-restart, then released pins
    wr(cwc_pkg::OFS_SD, 8'h7c);
    drv(1'b1, 1'b1);
    cyc(8);
    chk_pins(pins, 4'hf);
    rd(cwc_pkg::OFS_SD, 8'hfc);
    drv(1'b1, 1'b0);
    cyc(10);
    rd(cwc_pkg::OFS_SD, 8'h7c);
    wr(cwc_pkg::OFS_SD, 8'h54);
    drv(1'b1, 1'b1);
    cyc(8);
    chk_pins(oe, 4'h0);
    drv(1'b1, 1'b0);
    cyc(40);
    // Code 00 waits out the falling count before going inactive
    wr(cwc_pkg::OFS_POL, 8'h00);
    wr(cwc_pkg::OFS_SD, 8'h40);
    drv(1'b0, 1'b0);
    cyc(40);
    drv(1'b1, 1'b0);
    cyc(40);
    chk_pins(pins, 4'h5);
    drv(1'b1, 1'b1);
    cyc(8);
    chk_pins(pins, 4'h5);
    cyc(30);
    chk_pins(pins, 4'h0);
    chk_pins(oe, 4'hf);
    drv(1'b1, 1'b0);
    cyc(40);
    // Shutdown forced while disabled
    wr(cwc_pkg::OFS_MAIN, 8'h04);
    wr(cwc_pkg::OFS_SD, 8'h98);
    rd(cwc_pkg::OFS_SD, 8'h98);
    cyc(4);
    chk_pins(oe, 4'h5);
    chk_pins(pins, 4'h0);
    report_and_stop;
  end
endmodule
